//--- core/sfd_dma_top.sv
// two-channel dma engine between host memory and four on-board fifo locations
// assumes: all ports on clock_in;
// request pins are asynchronous and synchronised here
`timescale 1ns/10ps
`include "sfd_cfg.svh"
module sfd_dma_top
    import sfd_pkg::*;
#(
    parameter int FIFO_W = `SFD_FIFO_W,
    parameter int FIFO_D = `SFD_FIFO_D
)
(
    input  wire logic        clock_in,
    input  wire logic        resetn_in,
    input  wire logic        ce_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    output logic             mem_req_out,
    output logic             mem_we_out,
    output logic      [31:0] mem_addr_out,
    output logic      [31:0] mem_wdata_out,
    input  wire logic        mem_ack_in,
    input  wire logic [31:0] mem_rdata_in,
    output logic             loc_req_out,
    output logic             loc_we_out,
    output logic      [1:0]  loc_sel_out,
    output logic      [31:0] loc_wdata_out,
    input  wire logic [31:0] loc_rdata_in,
    input  wire logic        loc_ready_n_in,
    output logic             burst_last_n_out,
    input  wire logic [1:0]  dma_request_n_in
);
    typedef struct packed
    {
        sfd_chan_t [1:0]  ch;
        logic [31:0]      range;
        logic [1:0][31:0] mbox;
        logic [31:0]      rdata;
        logic [1:0]       rq1;
        logic [1:0]       rq2;
        sfd_state_t       fsm;
        logic             ach;
        logic             dir;
        logic             eoc;
        logic [31:0]      haddr;
        logic [29:0]      wrem;
        logic [31:0]      dnext;
        logic [1:0]       didx;
        logic [1:0]       lane;
        logic [31:0]      asm_w;
        logic             gap;
        logic             mreq;
        logic             mwe;
        logic [31:0]      maddr;
        logic [31:0]      mwdata;
        logic             lreq;
        logic             lwe;
        logic [1:0]       lsel;
        logic [31:0]      lwdata;
        logic             burst_last_n_n;
    } st_t;

    localparam st_t ST_RST = '{range: `SFD_RANGE_4K, rq1: 2'h3, rq2: 2'h3,
                              fsm: ST_IDLE, burst_last_n_n: 1'b1, default: '0};

    st_t         st_r;
    st_t         st_nxt;
    logic [31:0] cm;
    logic [31:0] sm;
    logic [31:0] rmux;
    logic        w32;
    logic        lastlane;
    logic        lgo;
    logic        ldone;
    logic        mdone;
    logic        stop;
    logic        c;
    logic        push_v;
    logic        pop_r;
    logic [1:0]  set_done;
    logic [1:0]  set_err;

    sfd_fifo_if #(.W(FIFO_W), .D(FIFO_D)) fq ();

    sfd_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo
    (
        .clock_in  (clock_in),
        .resetn_in (resetn_in),
        .f         (fq.store)
    );

    // mode of the channel in service
    assign cm       = st_r.ch[st_r.ach].mode;
    assign w32      = cm[`SFD_MB_WID_HI:`SFD_MB_WID_LO] == `SFD_W32;
    assign lastlane = w32 || (st_r.lane == 2'h3);
    assign stop     = cm[`SFD_MB_STOP];
    // demand mode waits for a low request
    assign lgo      = !st_r.lreq && !st_r.gap
                      && (!cm[`SFD_MB_DEMAND] || !st_r.rq2[st_r.ach]);
    // without ready enable an access lasts one cycle
    assign ldone    = st_r.lreq && (!cm[`SFD_MB_RDY] || !loc_ready_n_in);
    assign mdone    = st_r.mreq && mem_ack_in;

    // fifo side of the data path
    assign fq.ce         = ce_in;
    assign fq.push_valid = push_v;
    assign fq.pop_ready  = pop_r;
    assign fq.push_data  = !st_r.dir ? mem_rdata_in :
                           w32 ? loc_rdata_in : {loc_rdata_in[7:0], st_r.asm_w[23:0]};

    // read mux; unmapped offsets read zero
    always_comb
    begin
        rmux = 32'h0;
        if (reg_addr_in == `SFD_OFF_RANGE)
            rmux = st_r.range;
        if (reg_addr_in == `SFD_OFF_MBOX0)
            rmux = st_r.mbox[0];
        if (reg_addr_in == `SFD_OFF_MBOX1)
            rmux = st_r.mbox[1];
        for (int i = 0; i < 2; i++)
        begin
            if (reg_addr_in == 8'(`SFD_OFF_MODE0 + i * `SFD_CH_STRIDE))
                rmux = st_r.ch[i].mode;
            if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_HADDR))
                rmux = st_r.ch[i].haddr;
            if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_LADDR))
                rmux = st_r.ch[i].laddr;
            if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_COUNT))
                rmux = st_r.ch[i].count;
            if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_DESC))
                rmux = st_r.ch[i].desc;
        end
        if (reg_addr_in == `SFD_OFF_CMD)
        begin
            for (int i = 0; i < 2; i++)
            begin
                rmux[i * `SFD_C_STRIDE + `SFD_C_START] = st_r.ch[i].pend;
                rmux[i * `SFD_C_STRIDE + `SFD_C_DONE]  = st_r.ch[i].done;
                rmux[i * `SFD_C_STRIDE + `SFD_C_ERR]   = st_r.ch[i].err;
                rmux[i * `SFD_C_STRIDE + `SFD_C_BUSY]  = (st_r.fsm != ST_IDLE)
                                                         && (st_r.ach == 1'(i));
            end
        end
    end

    // engine, register writes, then status sets: a set beats a clear
    always_comb
    begin
        st_nxt   = st_r;
        push_v   = 1'b0;
        pop_r    = 1'b0;
        set_done = 2'h0;
        set_err  = 2'h0;
        c        = !st_r.ch[0].pend;
        sm       = st_r.ch[c].mode;
        st_nxt.rq1 = dma_request_n_in;
        st_nxt.rq2 = st_r.rq1;
        st_nxt.gap = 1'b0;
        if (reg_rd_in)
            st_nxt.rdata = rmux;

        unique case (st_r.fsm)
            ST_IDLE:
            begin
                // channel 0 wins a tie
                if (st_r.ch[0].pend || st_r.ch[1].pend)
                begin
                    st_nxt.ach       = c;
                    st_nxt.ch[c].pend = 1'b0;
                    st_nxt.lane      = 2'h0;
                    if (!sm[`SFD_MB_NOINC])
                    begin
                        // an incrementing address would leave the fifos
                        set_err[c]  = 1'b1;
                        set_done[c] = 1'b1;
                    end
                    else if (sm[`SFD_MB_CHAIN])
                    begin
                        st_nxt.dnext = {st_r.ch[c].desc[31:4], 4'h0};
                        st_nxt.didx  = 2'h0;
                        st_nxt.fsm   = ST_DESC;
                    end
                    else
                    begin
                        st_nxt.haddr = st_r.ch[c].haddr;
                        st_nxt.lsel  = st_r.ch[c].laddr[3:2];
                        st_nxt.wrem  = st_r.ch[c].count[31:2];
                        st_nxt.dir   = st_r.ch[c].desc[`SFD_D_DIR];
                        st_nxt.eoc   = 1'b1;
                        st_nxt.fsm   = ST_FILL;
                    end
                end
            end
            ST_DESC:
            begin
                // four words: host address, local address, count, next pointer
                if (!st_r.mreq)
                begin
                    st_nxt.mreq  = 1'b1;
                    st_nxt.mwe   = 1'b0;
                    st_nxt.maddr = st_r.dnext + {28'h0, st_r.didx, 2'h0};
                end
                else if (mdone)
                begin
                    st_nxt.mreq = 1'b0;
                    st_nxt.didx = st_r.didx + 2'h1;
                    unique case (st_r.didx)
                        2'h0: st_nxt.haddr = mem_rdata_in;
                        2'h1: st_nxt.lsel  = mem_rdata_in[3:2];
                        2'h2: st_nxt.wrem  = mem_rdata_in[31:2];
                        2'h3:
                        begin
                            st_nxt.dnext = {mem_rdata_in[31:4], 4'h0};
                            st_nxt.eoc   = mem_rdata_in[`SFD_D_EOC];
                            st_nxt.dir   = mem_rdata_in[`SFD_D_DIR];
                            st_nxt.lane  = 2'h0;
                            st_nxt.fsm   = ST_FILL;
                        end
                    endcase
                end
            end
            ST_FILL:
            begin
                // fill until full or the segment is fetched
                if (!st_r.mreq && !st_r.lreq && (st_r.wrem == 30'h0 || !fq.push_ready))
                    st_nxt.fsm = ST_DRAIN;
                else if (!st_r.dir)
                begin
                    if (!st_r.mreq)
                    begin
                        st_nxt.mreq  = 1'b1;
                        st_nxt.mwe   = 1'b0;
                        st_nxt.maddr = st_r.haddr;
                    end
                    else if (mdone)
                    begin
                        st_nxt.mreq  = 1'b0;
                        push_v       = 1'b1;
                        st_nxt.haddr = st_r.haddr + 32'h4;
                        st_nxt.wrem  = st_r.wrem - 30'h1;
                    end
                end
                else if (lgo)
                begin
                    st_nxt.lreq    = 1'b1;
                    st_nxt.lwe     = 1'b0;
                    st_nxt.burst_last_n_n = !(st_r.wrem == 30'h1 && lastlane && !stop);
                end
                else if (ldone)
                begin
                    st_nxt.lreq    = 1'b0;
                    st_nxt.burst_last_n_n = 1'b1;
                    st_nxt.gap     = !cm[`SFD_MB_BURST];
                    st_nxt.asm_w[st_r.lane * 8 +: 8] = loc_rdata_in[7:0];
                    st_nxt.lane    = lastlane ? 2'h0 : st_r.lane + 2'h1;
                    if (lastlane)
                    begin
                        push_v      = 1'b1;
                        st_nxt.wrem = st_r.wrem - 30'h1;
                    end
                end
            end
            ST_DRAIN:
            begin
                // empty the fifo to the destination
                if (!st_r.mreq && !st_r.lreq && !fq.pop_valid)
                    st_nxt.fsm = (st_r.wrem == 30'h0) ? ST_NEXT : ST_FILL;
                else if (st_r.dir)
                begin
                    if (!st_r.mreq)
                    begin
                        st_nxt.mreq   = 1'b1;
                        st_nxt.mwe    = 1'b1;
                        st_nxt.maddr  = st_r.haddr;
                        st_nxt.mwdata = fq.pop_data;
                    end
                    else if (mdone)
                    begin
                        st_nxt.mreq  = 1'b0;
                        pop_r        = 1'b1;
                        st_nxt.haddr = st_r.haddr + 32'h4;
                    end
                end
                else if (lgo)
                begin
                    st_nxt.lreq    = 1'b1;
                    st_nxt.lwe     = 1'b1;
                    st_nxt.lwdata  = w32 ? fq.pop_data
                                         : {24'h0, fq.pop_data[st_r.lane * 8 +: 8]};
                    st_nxt.burst_last_n_n = !(st_r.wrem == 30'h0 && lastlane && !stop
                                       && fq.level == ($clog2(FIFO_D) + 1)'(1));
                end
                else if (ldone)
                begin
                    st_nxt.lreq    = 1'b0;
                    st_nxt.burst_last_n_n = 1'b1;
                    st_nxt.gap     = !cm[`SFD_MB_BURST];
                    st_nxt.lane    = lastlane ? 2'h0 : st_r.lane + 2'h1;
                    pop_r          = lastlane;
                end
            end
            ST_NEXT:
            begin
                if (st_r.eoc)
                begin
                    set_done[st_r.ach] = 1'b1;
                    st_nxt.fsm         = ST_IDLE;
                end
                else
                begin
                    st_nxt.didx = 2'h0;
                    st_nxt.fsm  = ST_DESC;
                end
            end
        endcase

        // register writes; mailboxes only store
        if (reg_wr_in)
        begin
            if (reg_addr_in == `SFD_OFF_RANGE)
                st_nxt.range = reg_wdata_in;
            if (reg_addr_in == `SFD_OFF_MBOX0)
                st_nxt.mbox[0] = reg_wdata_in;
            if (reg_addr_in == `SFD_OFF_MBOX1)
                st_nxt.mbox[1] = reg_wdata_in;
            for (int i = 0; i < 2; i++)
            begin
                if (reg_addr_in == 8'(`SFD_OFF_MODE0 + i * `SFD_CH_STRIDE))
                    st_nxt.ch[i].mode = reg_wdata_in & `SFD_MODE_MASK;
                if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_HADDR))
                    st_nxt.ch[i].haddr = reg_wdata_in;
                if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_LADDR))
                    st_nxt.ch[i].laddr = reg_wdata_in;
                if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_COUNT))
                    st_nxt.ch[i].count = reg_wdata_in;
                if (reg_addr_in == `SFD_CH_OFF(i, `SFD_OFF_DESC))
                    st_nxt.ch[i].desc = reg_wdata_in;
                if (reg_addr_in == `SFD_OFF_CMD)
                begin
                    if (reg_wdata_in[i * `SFD_C_STRIDE + `SFD_C_START])
                        st_nxt.ch[i].pend = 1'b1;
                    if (reg_wdata_in[i * `SFD_C_STRIDE + `SFD_C_DONE])
                        st_nxt.ch[i].done = 1'b0;
                    if (reg_wdata_in[i * `SFD_C_STRIDE + `SFD_C_ERR])
                        st_nxt.ch[i].err = 1'b0;
                end
            end
        end

        // hardware sets beat a same-cycle clear
        for (int i = 0; i < 2; i++)
        begin
            st_nxt.ch[i].done = st_nxt.ch[i].done | set_done[i];
            st_nxt.ch[i].err  = st_nxt.ch[i].err | set_err[i];
        end
    end

    // ce low freezes engine and, through the carrier, the fifo
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_r <= ST_RST;
        else if (ce_in)
            st_r <= st_nxt;
    end

    // outputs straight from the state register
    assign reg_rdata_out    = st_r.rdata;
    assign mem_req_out      = st_r.mreq;
    assign mem_we_out       = st_r.mwe;
    assign mem_addr_out     = st_r.maddr;
    assign mem_wdata_out    = st_r.mwdata;
    assign loc_req_out      = st_r.lreq;
    assign loc_we_out       = st_r.lwe;
    assign loc_sel_out      = st_r.lsel;
    assign loc_wdata_out    = st_r.lwdata;
    assign burst_last_n_out = st_r.burst_last_n_n;
endmodule

//--- core/sfd_fifo.sv
// staging fifo of W bits by D entries, flip-flop storage
// assumes: D is a power of two; ce from the engine freezes it
`timescale 1ns/10ps
module sfd_fifo
#(
    parameter int W = 32,
    parameter int D = 16
)
(
    input  wire logic clock_in,
    input  wire logic resetn_in,
    sfd_fifo_if.store f
);
    localparam int AW = $clog2(D);

    typedef struct packed
    {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } sfd_fifo_st_t;

    sfd_fifo_st_t st_r;
    sfd_fifo_st_t st_nxt;
    logic         push;
    logic         pop;

    // handshakes and honest flags
    assign f.push_ready = st_r.cnt != (AW+1)'(D);
    assign f.pop_valid  = st_r.cnt != '0;
    assign f.pop_data   = st_r.mem[st_r.rp];
    assign f.level      = st_r.cnt;
    assign push         = f.push_valid && f.push_ready;
    assign pop          = f.pop_valid && f.pop_ready;

    // pointers wrap on their own since depth is a power of two
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = f.push_data;
            st_nxt.wp           = st_r.wp + 1'b1;
        end
        if (pop)
            st_nxt.rp = st_r.rp + 1'b1;
        if (push && !pop)
            st_nxt.cnt = st_r.cnt + 1'b1;
        else if (pop && !push)
            st_nxt.cnt = st_r.cnt - 1'b1;
    end

    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
            st_r <= '0;
        else if (f.ce)
            st_r <= st_nxt;
    end
endmodule

//--- shared/sfd_cfg.svh
// offsets, field positions and reset values of the dma block
// assumes: included by bare name; 8-bit register index, 32-bit data
`ifndef SFD_CFG_SVH
`define SFD_CFG_SVH

`define SFD_OFF_RANGE   8'h00
`define SFD_OFF_MBOX0   8'h40
`define SFD_OFF_MBOX1   8'h44
`define SFD_OFF_MODE0   8'h80
`define SFD_OFF_MODE1   8'h94
`define SFD_CH_STRIDE   8'h14
`define SFD_OFF_HADDR   8'h04
`define SFD_OFF_LADDR   8'h08
`define SFD_OFF_COUNT   8'h0C
`define SFD_OFF_DESC    8'h10
`define SFD_OFF_CMD     8'hA8
`define SFD_CH_OFF(i, o) 8'(`SFD_OFF_MODE0 + (i) * `SFD_CH_STRIDE + (o))

`define SFD_RANGE_4K    32'hFFFF_F000
`define SFD_MODE_MASK   32'h0003_FFFF

`define SFD_MB_WID_HI   1
`define SFD_MB_WID_LO   0
`define SFD_W32         2'h3
`define SFD_W8          2'h0
`define SFD_MB_RDY      6
`define SFD_MB_BURST    8
`define SFD_MB_CHAIN    9
`define SFD_MB_NOINC    11
`define SFD_MB_DEMAND   12
`define SFD_MB_STOP     15

`define SFD_D_EOC       1
`define SFD_D_DIR       3

`define SFD_C_STRIDE    8
`define SFD_C_START     0
`define SFD_C_DONE      4
`define SFD_C_ERR       5
`define SFD_C_BUSY      6

`define SFD_FIFO_W      32
`define SFD_FIFO_D      16

`endif

//--- shared/sfd_fifo_if.sv
// carrier between the dma engine and its staging fifo
// assumes: both ends on one clock
`timescale 1ns/10ps
interface sfd_fifo_if #(parameter int W = 32, parameter int D = 16);
    logic              ce;
    logic              push_valid;
    logic              push_ready;
    logic [W-1:0]      push_data;
    logic              pop_valid;
    logic              pop_ready;
    logic [W-1:0]      pop_data;
    logic [$clog2(D):0] level;

    modport engine (output ce, push_valid, push_data, pop_ready,
                    input  push_ready, pop_valid, pop_data, level);
    modport store  (input  ce, push_valid, push_data, pop_ready,
                    output push_ready, pop_valid, pop_data, level);
endinterface

//--- shared/sfd_pkg.sv
// types shared by the fifo dma channel block
// assumes: nothing beyond plain SystemVerilog
package sfd_pkg;

    // engine states, one-hot
    typedef enum logic [4:0]
    {
        ST_IDLE  = 5'h01,
        ST_DESC  = 5'h02,
        ST_FILL  = 5'h04,
        ST_DRAIN = 5'h08,
        ST_NEXT  = 5'h10
    } sfd_state_t;

    // software view of one channel
    typedef struct packed
    {
        logic [31:0] mode;
        logic [31:0] haddr;
        logic [31:0] laddr;
        logic [31:0] count;
        logic [31:0] desc;
        logic        pend;
        logic        done;
        logic        err;
    } sfd_chan_t;

endpackage

//--- sim/sfd_dma_monitor.sv
// port assertions for the two-channel fifo dma engine
// assumes: bound to sfd_dma_top, everything on clock_in
`timescale 1ns/10ps
module sfd_dma_monitor
(
    input wire logic        clock_in,
    input wire logic        resetn_in,
    input wire logic        ce_in,
    input wire logic        reg_rd_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        mem_req_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic        mem_ack_in,
    input wire logic        loc_req_out,
    input wire logic [1:0]  loc_sel_out,
    input wire logic        burst_last_n_out
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!resetn_in);

    // burst-last only within an access
    chk_last_in_access: assert property (!burst_last_n_out |-> loc_req_out)
        else $error("last low outside access");
    chk_last_released: assert property ($fell(loc_req_out) |-> burst_last_n_out)
        else $error("last low after access");
    // fifo location steady within an access
    chk_sel_steady: assert property (loc_req_out && $past(loc_req_out) |-> $stable(loc_sel_out))
        else $error("location moved in access");
    // host request stands until acknowledged, one idle cycle after
    chk_mem_holds: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
        else $error("request moved before ack");
    chk_mem_gap: assert property (mem_req_out && mem_ack_in && ce_in |=> !mem_req_out)
        else $error("request held after ack");
    // upper mode bits are reserved and read zero
    chk_mode_reserved: assert property (reg_rd_in && ce_in && (reg_addr_in == 8'h80 ||
        reg_addr_in == 8'h94) |=> reg_rdata_out[31:18] == 14'h0)
        else $error("reserved bits set");
    chk_unmapped_zero: assert property (reg_rd_in && ce_in && reg_addr_in == 8'hF0
        |=> reg_rdata_out == 32'h0)
        else $error("unmapped read non-zero");
    chk_reset_idle: assert property ($rose(resetn_in) |-> burst_last_n_out && !loc_req_out
        && !mem_req_out)
        else $error("busy at reset release");
endmodule

bind sfd_dma_top sfd_dma_monitor u_mon (.clock_in, .resetn_in, .ce_in, .reg_rd_in,
    .reg_addr_in, .reg_rdata_out, .mem_req_out, .mem_addr_out, .mem_ack_in,
    .loc_req_out, .loc_sel_out, .burst_last_n_out);

//--- sim/sfd_dma_top_bench.sv
// self-checking bench for the two-channel fifo dma engine
// assumes: sfd_far_model answers host memory and fifo accesses
`timescale 1ns/10ps
module sfd_dma_top_bench;
    logic        clock_in, resetn_in, ce_in, reg_wr_in, reg_rd_in, mem_req_out;
    logic        mem_we_out, mem_ack_in, loc_req_out, loc_we_out, loc_ready_n_in;
    logic        burst_last_n_out;
    logic [1:0]  loc_sel_out, dma_request_n_in, slow, want;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
    logic [31:0] loc_wdata_out, loc_rdata_in, rd, w;
    int          fail_count = 0;
    int          checked = 0;
    int          n0, i;

    sfd_dma_top u_dut (.*);
    sfd_far_model u_far (.clock_in, .slow_in(slow), .want_in(want), .mreq_in(mem_req_out),
        .mwe_in(mem_we_out), .maddr_in(mem_addr_out), .mwdata_in(mem_wdata_out),
        .mack_out(mem_ack_in), .mrdata_out(mem_rdata_in), .lreq_in(loc_req_out),
        .lwdata_in(loc_wdata_out), .lsel_in(loc_sel_out), .llast_n_in(burst_last_n_out),
        .lrdata_out(loc_rdata_in), .lready_n_out(loc_ready_n_in),
        .lwe_in(loc_we_out), .request_n_out(dma_request_n_in));

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes set at the falling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clock_in);
        reg_wr_in = 1'b0;
    endtask
    task automatic get(input logic [7:0] a);
        @(negedge clock_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clock_in);
        reg_rd_in = 1'b0;
        rd = reg_rdata_out;
    endtask
    // program a channel; clear flags and start in one write
    task automatic run(input int ch, input logic [31:0] m, h, l, c, d);
        logic [7:0] b = 8'h80 + 8'(ch * 20);
        n0 = u_far.n_acc;
        wr(b, m);
        wr(b + 8'h04, h);
        wr(b + 8'h08, l);
        wr(b + 8'h0C, c);
        wr(b + 8'h10, d);
        wr(8'hA8, 32'h31 << (ch * 8));
    endtask
    // bounded poll of done; a hang fails the run
    task automatic wait_done(input int ch);
        int k = 0;
        do
        begin
            get(8'hA8);
            k++;
        end
        while (rd[ch * 8 + 4] !== 1'b1 && k < 300);
        if (k >= 300)
        begin
            fail_count++;
            complete_run();
        end
    endtask

    initial
    begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // bit 16 stays clear; byte packing only without demand
    initial
    begin
        {resetn_in, reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in, slow, want} = '0;
        ce_in = 1'b1;
        u_far.mem[4] = 32'h1122_3344;
        u_far.mem[5] = 32'h5566_7788;
        {u_far.mem[32], u_far.mem[33], u_far.mem[34]} = {32'h10, 32'hC, 32'h4};
        u_far.mem[35] = 32'h2;
        repeat (8) @(negedge clock_in);
        resetn_in = 1'b1;
        get(8'h00);
        compare(rd, 32'hFFFF_F000);
        for (i = 0; i < 2; i++)
        begin
            get(8'h80 + 8'(i * 20));
            compare(rd, 32'h0);
            wr(8'h80 + 8'(i * 20), 32'hFFFF_FFFF);
            get(8'h80 + 8'(i * 20));
            compare(rd, 32'h0003_FFFF);
        end
        wr(8'h40, 32'hA5A5_0F0F);
        wr(8'hF0, 32'h1234_5678);
        get(8'h40);
        compare(rd, 32'hA5A5_0F0F);
        get(8'hF0);
        compare(rd, 32'h0);
        ce_in = 1'b0;
        wr(8'h80, 32'h0);
        ce_in = 1'b1;
        get(8'h80);
        compare(rd, 32'h0003_FFFF);
        // word transmit, two words to location 2
        run(0, 32'h903, 32'h10, 32'h8, 32'h8, 32'h0);
        wait_done(0);
        compare(u_far.n_acc - n0, 2);
        compare(u_far.log_d[n0], 32'h1122_3344);
        compare(u_far.log_d[n0 + 1], 32'h5566_7788);
        compare(u_far.log_s[n0], 4'hE);
        compare(u_far.log_s[n0 + 1], 4'hA);
        // byte receive, ready, slow host: byte 0 lowest
        slow = 2'h2;
        i = u_far.n_end;
        run(1, 32'h2940, 32'h40, 32'h4, 32'h4, 32'h8);
        wait_done(1);
        w = {8'hA3 + 8'(i), 8'hA2 + 8'(i), 8'hA1 + 8'(i), 8'hA0 + 8'(i)};
        compare(u_far.mem[16], w);
        compare(u_far.log_s[n0 + 3], 4'h1);
        // demand mode waits for the request
        slow = 2'h0;
        run(0, 32'h1903, 32'h10, 32'h0, 32'h4, 32'h0);
        repeat (40) @(negedge clock_in);
        compare(u_far.n_acc - n0, 0);
        want = 2'h1;
        wait_done(0);
        compare(u_far.n_acc - n0, 1);
        want = 2'h0;
        // chained segment from a host descriptor
        run(1, 32'hB03, 32'h0, 32'h0, 32'h0, 32'h80);
        wait_done(1);
        compare(u_far.log_d[n0], 32'h1122_3344);
        compare(u_far.log_s[n0], 4'hB);
        // incrementing address is refused
        run(0, 32'h3, 32'h10, 32'h0, 32'h4, 32'h0);
        wait_done(0);
        compare({31'h0, rd[5]}, 32'h1);
        compare(u_far.n_acc - n0, 0);
        complete_run();
    end
endmodule

//--- sim/sfd_far_model.sv
// far side: host memory plus the on-board fifo logic
// assumes: same clock as the engine; bench loads mem and reads the log
`timescale 1ns/10ps
module sfd_far_model
(
    input  wire logic        clock_in,
    input  wire logic [1:0]  slow_in,
    input  wire logic [1:0]  want_in,
    input  wire logic        mreq_in,
    input  wire logic        mwe_in,
    input  wire logic [31:0] maddr_in,
    input  wire logic [31:0] mwdata_in,
    output logic             mack_out,
    output logic      [31:0] mrdata_out,
    input  wire logic        lreq_in,
    input  wire logic [31:0] lwdata_in,
    input  wire logic [1:0]  lsel_in,
    input  wire logic        llast_n_in,
    input  wire logic        lwe_in,
    output logic      [31:0] lrdata_out,
    output logic             lready_n_out,
    output logic      [1:0]  request_n_out
);
    logic [31:0] mem [0:63];
    logic [31:0] log_d [0:15];
    logic [3:0]  log_s [0:15];
    logic [1:0]  wcnt;
    logic        lreq_d;
    int          n_acc = 0;
    int          n_end = 0;

    // fifo logic asks for demand transfers, active low
    assign request_n_out = ~want_in;
    // host data valid only when acknowledged, fifo data whenever requested
    assign mrdata_out = mem[maddr_in[7:2]] ^ {32{!mack_out}};
    assign lrdata_out = {24'h0, 8'hA0 + 8'(n_end)} ^ {32{!lreq_in}};

    // ack after slow_in waits, ready after one wait, log each fifo access
    always @(posedge clock_in)
    begin
        lreq_d <= lreq_in;
        mack_out <= mreq_in && !mack_out && wcnt == slow_in;
        wcnt <= (mreq_in && !mack_out && wcnt != slow_in) ? wcnt + 2'h1 : 2'h0;
        lready_n_out <= !(lreq_in && lready_n_out);
        if (mack_out && mreq_in && mwe_in)
            mem[maddr_in[7:2]] <= mwdata_in;
        if (lreq_in && !lreq_d)
        begin
            log_d[n_acc[3:0]] <= lwdata_in;
            log_s[n_acc[3:0]] <= {lwe_in, llast_n_in, lsel_in};
            n_acc <= n_acc + 1;
        end
        if (lreq_d && !lreq_in)
            n_end <= n_end + 1;
    end
endmodule
